// ### logic/crf_pkg.sv
/*
  Constants and types shared by the core datapath state block: register
  offsets on the APB side, status flag layout, operation codes and the
  data-space map.
  Assumes a single 100 MHz clock domain and a synchronous active-low reset.
*/
`default_nettype none

package crf_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] CRF_OFF_STATUS  = 12'h0_000;
  localparam logic [11:0] CRF_OFF_PTR_X   = 12'h0_004;
  localparam logic [11:0] CRF_OFF_PTR_Y   = 12'h0_008;
  localparam logic [11:0] CRF_OFF_PTR_Z   = 12'h0_00C;
  localparam logic [11:0] CRF_OFF_RF_BASE = 12'h0_080;
  localparam logic [7:0]  CRF_STATUS_RST  = 8'h0_0;

  // ----------------------------------------------------------------------
  // Register file and data-space layout
  // ----------------------------------------------------------------------
  localparam int          CRF_NUM_REGS    = 32;
  localparam logic [4:0]  CRF_PTR_X_LO    = 5'h1_A;
  localparam logic [4:0]  CRF_PTR_Y_LO    = 5'h1_C;
  localparam logic [4:0]  CRF_PTR_Z_LO    = 5'h1_E;
  localparam logic [15:0] CRF_IO_BASE     = 16'h0_020;
  localparam logic [15:0] CRF_RF_LIMIT    = 16'h0_020;

  // ----------------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------------
  localparam int CRF_BIT_I = 7;
  localparam int CRF_BIT_T = 6;
  localparam int CRF_BIT_H = 5;
  localparam int CRF_BIT_S = 4;
  localparam int CRF_BIT_V = 3;
  localparam int CRF_BIT_N = 2;
  localparam int CRF_BIT_Z = 1;
  localparam int CRF_BIT_C = 0;

  typedef enum logic [4:0] {
    CRF_OP_NOP  = 5'h0_0, CRF_OP_ADD  = 5'h0_1, CRF_OP_ADC  = 5'h0_2,
    CRF_OP_SUB  = 5'h0_3, CRF_OP_SBC  = 5'h0_4, CRF_OP_SUBI = 5'h0_5,
    CRF_OP_AND  = 5'h0_6, CRF_OP_OR   = 5'h0_7, CRF_OP_EOR  = 5'h0_8,
    CRF_OP_MOV  = 5'h0_9, CRF_OP_LDI  = 5'h0_A, CRF_OP_ADIW = 5'h0_B,
    CRF_OP_SBIW = 5'h0_C, CRF_OP_MOVW = 5'h0_D, CRF_OP_BST  = 5'h0_E,
    CRF_OP_BLD  = 5'h0_F, CRF_OP_SEI  = 5'h1_0, CRF_OP_CLI  = 5'h1_1,
    CRF_OP_RETURN_FROM_IRQ_INSTR = 5'h1_2, CRF_OP_LD   = 5'h1_3, CRF_OP_ST   = 5'h1_4,
    CRF_OP_LPM  = 5'h1_5, CRF_OP_IN   = 5'h1_6, CRF_OP_OUT  = 5'h1_7
  } crf_opc_t;

  typedef enum logic [1:0] {
    CRF_PTR_X = 2'h0, CRF_PTR_Y = 2'h1, CRF_PTR_Z = 2'h2
  } crf_ptr_sel_t;

  typedef enum logic [1:0] {
    CRF_AM_PLAIN = 2'h0, CRF_AM_POSTINC = 2'h1,
    CRF_AM_PREDEC = 2'h2, CRF_AM_DISP = 2'h3
  } crf_amode_t;

  typedef struct packed {
    crf_opc_t     opc;
    logic [4:0]   rd;
    logic [4:0]   rr;
    logic [7:0]   imm;
    crf_ptr_sel_t ptr;
    crf_amode_t   amode;
    logic [5:0]   disp;
    logic [2:0]   bitsel;
  } crf_op_t;

  typedef struct packed {
    logic        i;
    logic        t;
    logic        h;
    logic        s;
    logic        v;
    logic        n;
    logic        z;
    logic        c;
  } crf_flags_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
    logic        prog;
  } crf_mem_req_t;

  typedef struct packed {
    logic [7:0]  res;
    crf_flags_t  f;
  } crf_alu_t;

endpackage : crf_pkg

`default_nettype wire

// ### logic/crf_core.sv
/*
  Core datapath state: working register file, pointer pairs, status flags
  and a one-deep fetch register that overlaps fetch with execution.
  Assumes an operation source on the same clock, an interrupt controller
  that raises irq_req_in as a level, a data/program memory that answers a
  read with mem_rvalid_in some cycles later, and an APB master.
*/
// Overview of operation
// - Next operation is fetched while the current one executes.
// - Thirty-two eight-bit registers, each accessed in one cycle.
// - ALU reads two operands, computes, writes back within one cycle.
// - Ports: 8r/8w, 2x8r/8w, 2x8r/16w and 16r/16w arrangements.
// - Top six registers form the X, Y and Z sixteen-bit pointers.
// - Z pointer also addresses program memory table lookups.
// - Pointers offer displacement, post-increment and pre-decrement modes.
// - Data addresses below 32 reach the register file itself.
// - Sixty-four I/O addresses sit at data addresses 0x20 to 0x5F.
// - Extended I/O above 0x5F is reached only by data loads and stores.
// - Status flags update after every ALU operation.
// - Status flags are neither saved nor restored around interrupts.
// - Global enable clear blocks every interrupt.
// - Taking an interrupt clears global enable; return sets it again.
// - Set and clear interrupt operations write the global enable directly.
// - Bit six is the bit-copy store for bit store and bit load.
// - Bit five holds the low-nibble half carry for arithmetic.
// - Sign flag is set to negative xor overflow by every ALU and word arithmetic update; bit copy, enable and APB status writes do not set it so.
// - Bit three holds two's complement overflow.
// - Bit two is set when the result's top bit is one.
// - Bit one is set when the result is zero.
// - Bit zero holds the operation's carry.
`default_nettype none

module crf_core (
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  nrst_in,
  // APB slave
  input  wire logic [11:0]           paddr_in,
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [31:0]           pwdata_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // Operation stream
  input  wire crf_pkg::crf_op_t      op_in,
  input  wire logic                  op_valid_in,
  output logic                       op_ready_out,
  // Interrupt handshake
  input  wire logic                  irq_req_in,
  output logic                       irq_take_out,
  // Memory request and answer
  output crf_pkg::crf_mem_req_t      mem_req_out,
  input  wire logic [7:0]            mem_rdata_in,
  input  wire logic                  mem_rvalid_in,
  // Status view
  output crf_pkg::crf_flags_t        status_flags_out
);
  import crf_pkg::*;

  // ----------------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------------
  function automatic crf_alu_t alu8(input crf_opc_t op, input logic [7:0] a,
                                    input logic [7:0] b, input crf_flags_t f);
    crf_alu_t   o;
    logic       sub;
    logic       cin;
    logic [7:0] r;
    o   = '{res: a, f: f};
    sub = (op == CRF_OP_SUB) || (op == CRF_OP_SBC) || (op == CRF_OP_SUBI);
    cin = ((op == CRF_OP_ADC) || (op == CRF_OP_SBC)) ? f.c : 1'b0;
    case (op)
      CRF_OP_AND: r = a & b;
      CRF_OP_OR:  r = a | b;
      CRF_OP_EOR: r = a ^ b;
      default: begin
        if (sub) begin
          r = 8'(a - b - {7'h0_0, cin});
        end else begin
          r = 8'(a + b + {7'h0_0, cin});
        end
      end
    endcase
    o.res = r;
    if (sub) begin
      o.f.h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      o.f.v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      o.f.c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    end else if ((op == CRF_OP_ADD) || (op == CRF_OP_ADC)) begin
      o.f.h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
      o.f.v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
      o.f.c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
    end else begin
      o.f.v = 1'b0;
    end
    o.f.n = r[7];
    // Carry-chained subtract keeps zero only if all earlier bytes were zero.
    if (op == CRF_OP_SBC) begin
      o.f.z = f.z & (r == 8'h0_0);
    end else begin
      o.f.z = (r == 8'h0_0);
    end
    o.f.s = o.f.n ^ o.f.v;
    return o;
  endfunction : alu8

  function automatic logic [4:0] ptr_lo(input crf_ptr_sel_t p);
    case (p)
      CRF_PTR_X: return CRF_PTR_X_LO;
      CRF_PTR_Y: return CRF_PTR_Y_LO;
      default:   return CRF_PTR_Z_LO;
    endcase
  endfunction : ptr_lo

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CRF_ST_EXEC = 2'b01,
    CRF_ST_WAIT = 2'b10
  } crf_state_t;

  crf_state_t   state_q, state_d;
  logic [7:0]   rf_q [CRF_NUM_REGS];
  crf_flags_t   flags_q, flags_d;
  crf_op_t      op_q;
  logic         op_v_q, op_v_d;
  logic         ready_q;
  logic [4:0]   ld_rd_q;
  logic         irq_take_q;
  crf_mem_req_t mem_q, mem_d;
  logic [31:0]  prdata_q;
  logic         pready_q;
  logic         pslverr_q;

  // ----------------------------------------------------------------------
  // Operand reads and execute decode
  // ----------------------------------------------------------------------
  wire logic        accept   = op_valid_in & ready_q;
  wire logic        consume  = (state_q == CRF_ST_EXEC) & op_v_q;
  wire crf_opc_t    opc      = consume ? op_q.opc : CRF_OP_NOP;
  wire logic [7:0]  rd_val   = rf_q[op_q.rd];
  wire logic [7:0]  rr_val   = rf_q[op_q.rr];
  wire logic [4:0]  rd_hi    = op_q.rd | 5'h0_1;
  wire logic [15:0] rd_word  = {rf_q[rd_hi], rf_q[op_q.rd & 5'h1_E]};
  wire logic [4:0]  p_lo     = ptr_lo(op_q.ptr);
  wire logic [4:0]  p_hi     = p_lo | 5'h0_1;
  wire logic [15:0] p_val    = {rf_q[p_hi], rf_q[p_lo]};
  wire logic [15:0] p_dec    = 16'(p_val - 16'h0_001);
  wire logic [15:0] p_inc    = 16'(p_val + 16'h0_001);
  wire logic [7:0]  alu_b    = ((opc == CRF_OP_SUBI) || (opc == CRF_OP_LDI))
                               ? op_q.imm : rr_val;
  wire crf_alu_t    alu_o    = alu8(opc, rd_val, alu_b, flags_q);
  wire logic [15:0] w_res    = (opc == CRF_OP_SBIW)
                               ? 16'(rd_word - {10'h0_00, op_q.imm[5:0]})
                               : 16'(rd_word + {10'h0_00, op_q.imm[5:0]});
  wire logic        is_ptr   = (opc == CRF_OP_LD) || (opc == CRF_OP_ST);
  wire logic [15:0] eff_addr =
    (op_q.amode == CRF_AM_PREDEC) ? p_dec :
    (op_q.amode == CRF_AM_DISP)   ? 16'(p_val + {10'h0_00, op_q.disp}) :
                                    p_val;
  wire logic        in_rf    = eff_addr < CRF_RF_LIMIT;
  wire logic [4:0]  rf_slot  = eff_addr[4:0];
  wire logic        ptr_upd  = is_ptr && ((op_q.amode == CRF_AM_POSTINC) ||
                               (op_q.amode == CRF_AM_PREDEC));
  wire logic [15:0] ptr_new  = (op_q.amode == CRF_AM_PREDEC) ? p_dec : p_inc;
  // Direct I/O carries a six-bit address, so it can never reach above 0x5F.
  wire logic [15:0] io_addr  = CRF_IO_BASE + {10'h0_00, op_q.disp};
  wire logic        ext_ld   = ((opc == CRF_OP_LD) && !in_rf) ||
                               (opc == CRF_OP_LPM) || (opc == CRF_OP_IN);
  wire logic        irq_ok   = flags_q.i & irq_req_in;

  // ----------------------------------------------------------------------
  // Register write ports
  // ----------------------------------------------------------------------
  logic       w0_en, w1_en, w2_en;
  logic [4:0] w0_idx, w1_idx, w2_idx;
  logic [7:0] w0_val, w1_val, w2_val;

  always_comb begin
    w0_en  = 1'b0;
    w0_idx = op_q.rd;
    w0_val = alu_o.res;
    w1_en  = 1'b0;
    w1_idx = p_hi;
    w1_val = ptr_new[15:8];
    w2_en  = 1'b0;
    w2_idx = (opc == CRF_OP_LD) ? op_q.rd : rf_slot;
    w2_val = (opc == CRF_OP_LD) ? rf_q[rf_slot] : rd_val;
    case (opc)
      CRF_OP_ADD, CRF_OP_ADC, CRF_OP_SUB, CRF_OP_SBC, CRF_OP_SUBI,
      CRF_OP_AND, CRF_OP_OR, CRF_OP_EOR: begin
        w0_en = 1'b1;
      end
      CRF_OP_MOV: begin
        w0_en  = 1'b1;
        w0_val = rr_val;
      end
      CRF_OP_LDI: begin
        w0_en  = 1'b1;
        w0_val = op_q.imm;
      end
      CRF_OP_ADIW, CRF_OP_SBIW: begin
        w0_en  = 1'b1;
        w0_idx = op_q.rd & 5'h1_E;
        w0_val = w_res[7:0];
        w1_en  = 1'b1;
        w1_idx = rd_hi;
        w1_val = w_res[15:8];
      end
      CRF_OP_MOVW: begin
        w0_en  = 1'b1;
        w0_idx = op_q.rd & 5'h1_E;
        w0_val = rf_q[op_q.rr & 5'h1_E];
        w1_en  = 1'b1;
        w1_idx = rd_hi;
        w1_val = rf_q[op_q.rr | 5'h0_1];
      end
      CRF_OP_BLD: begin
        w0_en  = 1'b1;
        w0_val = rd_val;
        w0_val[op_q.bitsel] = flags_q.t;
      end
      CRF_OP_LD, CRF_OP_ST: begin
        w2_en  = in_rf;
        if (ptr_upd) begin
          w0_en  = 1'b1;
          w0_idx = p_lo;
          w0_val = ptr_new[7:0];
          w1_en  = 1'b1;
        end
      end
      default: begin
        w0_en = 1'b0;
      end
    endcase
    if ((state_q == CRF_ST_WAIT) && mem_rvalid_in) begin
      w0_en  = 1'b1;
      w0_idx = ld_rd_q;
      w0_val = mem_rdata_in;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags, memory request and sequencing
  // ----------------------------------------------------------------------
  wire logic [11:0] apb_addr = paddr_in;
  wire logic        apb_go   = psel_in & penable_in & pready_q;
  wire logic        apb_st   = apb_go & pwrite_in &
                               (apb_addr == CRF_OFF_STATUS);
  wire logic        apb_rf   = apb_addr[11:7] == CRF_OFF_RF_BASE[11:7];
  wire logic        apb_ptr  = (apb_addr == CRF_OFF_PTR_X) ||
                               (apb_addr == CRF_OFF_PTR_Y) ||
                               (apb_addr == CRF_OFF_PTR_Z);
  wire logic        apb_hit  = apb_rf || apb_ptr ||
                               (apb_addr == CRF_OFF_STATUS);
  wire logic [4:0]  apb_slot = apb_addr[6:2];
  wire logic [4:0]  apb_plo  = CRF_PTR_X_LO +
                               5'(apb_addr[3:2] - 2'h1) * 5'h0_2;

  always_comb begin
    flags_d = flags_q;
    case (opc)
      CRF_OP_ADD, CRF_OP_ADC, CRF_OP_SUB, CRF_OP_SBC, CRF_OP_SUBI,
      CRF_OP_AND, CRF_OP_OR, CRF_OP_EOR: begin
        flags_d = alu_o.f;
      end
      CRF_OP_ADIW, CRF_OP_SBIW: begin
        flags_d.n = w_res[15];
        flags_d.z = (w_res == 16'h0_000);
        flags_d.v = (opc == CRF_OP_ADIW) ? (~rd_word[15] & w_res[15])
                                         : (rd_word[15] & ~w_res[15]);
        flags_d.c = (opc == CRF_OP_ADIW) ? (rd_word[15] & ~w_res[15])
                                         : (~rd_word[15] & w_res[15]);
        flags_d.s = flags_d.n ^ flags_d.v;
      end
      CRF_OP_BST:  flags_d.t = rd_val[op_q.bitsel];
      CRF_OP_SEI:  flags_d.i = 1'b1;
      CRF_OP_CLI:  flags_d.i = 1'b0;
      CRF_OP_RETURN_FROM_IRQ_INSTR: flags_d.i = 1'b1;
      default:     flags_d = flags_q;
    endcase
    // Only the enable bit moves on entry; the rest is software's to save.
    if (irq_ok && !(opc == CRF_OP_CLI)) begin
      flags_d.i = 1'b0;
    end
    if (apb_st) begin
      flags_d = crf_flags_t'(pwdata_in[7:0]);
    end
  end

  always_comb begin
    mem_d       = '0;
    state_d     = state_q;
    mem_d.wdata = rd_val;
    case (state_q)
      CRF_ST_EXEC: begin
        if ((opc == CRF_OP_LD) || (opc == CRF_OP_ST)) begin
          mem_d.addr = eff_addr;
          mem_d.re   = (opc == CRF_OP_LD) && !in_rf;
          mem_d.we   = (opc == CRF_OP_ST) && !in_rf;
        end else if (opc == CRF_OP_LPM) begin
          mem_d.addr = {rf_q[CRF_PTR_Z_LO | 5'h0_1], rf_q[CRF_PTR_Z_LO]};
          mem_d.re   = 1'b1;
          mem_d.prog = 1'b1;
        end else if ((opc == CRF_OP_IN) || (opc == CRF_OP_OUT)) begin
          mem_d.addr = io_addr;
          mem_d.re   = (opc == CRF_OP_IN);
          mem_d.we   = (opc == CRF_OP_OUT);
        end
        if (ext_ld) begin
          state_d = CRF_ST_WAIT;
        end
      end
      CRF_ST_WAIT: begin
        if (mem_rvalid_in) begin
          state_d = CRF_ST_EXEC;
        end
      end
      default: state_d = CRF_ST_EXEC;
    endcase
    op_v_d = accept ? 1'b1 : (consume ? 1'b0 : op_v_q);
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state_q    <= CRF_ST_EXEC;
      flags_q    <= crf_flags_t'(CRF_STATUS_RST);
      op_q       <= '0;
      op_v_q     <= 1'b0;
      ready_q    <= 1'b0;
      ld_rd_q    <= 5'h0_0;
      irq_take_q <= 1'b0;
      mem_q      <= '0;
    end else begin
      state_q    <= state_d;
      flags_q    <= flags_d;
      op_v_q     <= op_v_d;
      ready_q    <= (state_d == CRF_ST_EXEC);
      irq_take_q <= irq_ok && !(opc == CRF_OP_CLI);
      mem_q      <= mem_d;
      if (accept) begin
        op_q <= op_in;
      end
      if (ext_ld) begin
        ld_rd_q <= op_q.rd;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register file storage
  // ----------------------------------------------------------------------
  // Core writes follow the APB write so that on a shared slot the core wins.
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < CRF_NUM_REGS; i++) begin
        rf_q[i] <= 8'h0_0;
      end
    end else begin
      if (apb_go && pwrite_in && apb_rf) begin
        rf_q[apb_slot] <= pwdata_in[7:0];
      end
      if (w2_en) begin
        rf_q[w2_idx] <= w2_val;
      end
      if (w0_en) begin
        rf_q[w0_idx] <= w0_val;
      end
      if (w1_en) begin
        rf_q[w1_idx] <= w1_val;
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // One wait state keeps pready a clean flop output at the cost of speed.
  logic [31:0] apb_rd;
  always_comb begin
    apb_rd = 32'h0_000_0000;
    if (apb_addr == CRF_OFF_STATUS) begin
      apb_rd = {24'h00_0000, flags_q};
    end else if (apb_ptr) begin
      apb_rd = {16'h0_000, rf_q[apb_plo | 5'h0_1], rf_q[apb_plo]};
    end else if (apb_rf) begin
      apb_rd = {24'h00_0000, rf_q[apb_slot]};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0_000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel_in & penable_in & ~pready_q;
      pslverr_q <= psel_in & penable_in & ~pready_q &
                   (~apb_hit | (apb_ptr & pwrite_in));
      if (psel_in && penable_in && !pready_q && !pwrite_in) begin
        prdata_q <= apb_rd;
      end
    end
  end

  assign prdata_out       = prdata_q;
  assign pready_out       = pready_q;
  assign pslverr_out      = pslverr_q;
  assign op_ready_out     = ready_q;
  assign irq_take_out     = irq_take_q;
  assign mem_req_out      = mem_q;
  assign status_flags_out = flags_q;

endmodule : crf_core

`default_nettype wire

// ### bench/crf_asserts.sv
/*
  Checker bound to crf_core: APB answer, reset state, flags, interrupts.
  Assumes crf_pkg is compiled first and only the core's ports are seen.
*/
`default_nettype none
module crf_asserts
  import crf_pkg::*;
(
  // Clock and reset
  input wire logic                  clk_sys_in,
  input wire logic                  nrst_in,
  // Watched ports
  input wire logic [11:0]           paddr_in,
  input wire logic                  psel_in,
  input wire logic                  penable_in,
  input wire logic                  pwrite_in,
  input wire logic                  pready_out,
  input wire logic                  pslverr_out,
  input wire crf_pkg::crf_op_t      op_in,
  input wire logic                  op_valid_in,
  input wire logic                  op_ready_out,
  input wire logic                  irq_take_out,
  input wire crf_pkg::crf_mem_req_t mem_req_out,
  input wire crf_pkg::crf_flags_t   status_flags_out
);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);
  // A status write over APB wins over a flag update, so it is excluded.
  wire logic st_wr;
  assign st_wr = psel_in && penable_in && pready_out && pwrite_in &&
                 paddr_in == CRF_OFF_STATUS;
  sequence add_s;
    op_valid_in && op_ready_out && op_in.opc == CRF_OP_ADD;
  endsequence
  apb_answer_a: assert property (psel_in && penable_in && !pready_out |=>
    pready_out) else $error("APB access not answered in one cycle");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("Slave error without ready");
  reset_state_a:
    assert property (disable iff (1'b0) !nrst_in |=> status_flags_out ==
      8'h00 && !pready_out && !irq_take_out) else $error("Reset state bad");
  sign_flag_a:
    assert property (add_s ##1 !st_wr |=> status_flags_out.s ==
      (status_flags_out.n ^ status_flags_out.v)) else $error("Sign flag bad");
  irq_gate_a:
    assert property (irq_take_out |-> $past(status_flags_out.i))
    else $error("Interrupt taken while disabled");
  irq_clear_a:
    assert property (irq_take_out |-> !status_flags_out.i)
    else $error("Global enable not cleared");
  irq_pulse_a: assert property (irq_take_out |=> !irq_take_out)
    else $error("Interrupt taken twice");
  ds_map_a:
    assert property ((mem_req_out.re || mem_req_out.we) && !mem_req_out.prog
      |-> mem_req_out.addr >= CRF_RF_LIMIT) else $error("Register in memory");
endmodule : crf_asserts

bind crf_core crf_asserts i_crf_asserts (.clk_sys_in, .nrst_in, .paddr_in,
  .psel_in, .penable_in, .pwrite_in, .pready_out, .pslverr_out, .op_in,
  .op_valid_in, .op_ready_out, .irq_take_out, .mem_req_out,
  .status_flags_out);
`default_nettype wire

// ### bench/test_cpu_regfile_status_flags.sv
/*
  Self-checking bench for crf_core: registers, ALU flags, pointer loads
  and interrupt gating, driven through APB and the operation port.
  Assumes crf_pkg and the bound checker are compiled first.
*/
`default_nettype none
module test_cpu_regfile_status_flags
  import crf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk_sys_in = '0, nrst_in = '0, psel_in = '0;
  logic         penable_in = '0, pwrite_in = '0, op_valid_in = '0;
  logic         irq_req_in = '0, mem_rvalid_in = '0, err_q;
  logic         pready_out, pslverr_out, op_ready_out, irq_take_out;
  logic [11:0]  paddr_in = '0;
  logic [31:0]  pwdata_in = '0, prdata_out, rd_q;
  logic [7:0]   mem_rdata_in = '0, a_q, b_q, ref_q [32];
  logic [15:0]  corner [4] = '{16'h8080, 16'h0F01, 16'hFF01, 16'h7F01};
  crf_op_t      op_in = '0;
  crf_mem_req_t mem_req_out;
  crf_flags_t   status_flags_out;
  int           err_total = 0, check_count = 0, takes = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  // Memory stand-in answers each load one cycle later with a known byte.
  always @(posedge clk_sys_in) begin
    mem_rvalid_in <= mem_req_out.re;
    mem_rdata_in <= mem_req_out.addr[7:0] ^ 8'h5A;
    if (irq_take_out === 1'b1) takes <= takes + 1;
  end
  crf_core i_crf_core (.clk_sys_in, .nrst_in, .paddr_in, .psel_in,
    .penable_in, .pwrite_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .op_in, .op_valid_in, .op_ready_out, .irq_req_in,
    .irq_take_out, .mem_req_out, .mem_rdata_in, .mem_rvalid_in,
    .status_flags_out);
  function automatic logic [11:0] ra(input int n);
    return CRF_OFF_RF_BASE + 12'(4 * n);
  endfunction : ra
  function automatic crf_op_t mk(crf_opc_t c, logic [4:0] d, logic [4:0] r,
    crf_ptr_sel_t p = CRF_PTR_X, crf_amode_t m = CRF_AM_PLAIN,
    logic [2:0] b = '0);
    return '{c, d, r, 8'h0, p, m, 6'h0, b};
  endfunction : mk
  function automatic logic [31:0] add_f(input logic [7:0] a, b);
    logic [8:0] s;
    logic       v;
    s = {1'b0, a} + {1'b0, b};
    v = a[7] == b[7] && s[7] != a[7];
    return {2'b0, a[3:0] + b[3:0] > 5'hF, s[7] ^ v, v, s[7],
            s[7:0] == 0, s[8]};
  endfunction : add_f
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys_in);
    {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, d};
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    {err_q, rd_q} = {pslverr_out, prdata_out};
    {psel_in, penable_in} <= 2'b00;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 0);
    chk(rd_q, exp);
  endtask : rchk
  task automatic do_op(input crf_op_t o);
    @(posedge clk_sys_in);
    {op_in, op_valid_in} <= {o, 1'b1};
    do @(posedge clk_sys_in); while (op_ready_out !== 1'b1);
    op_valid_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
  endtask : do_op
  task automatic give_verdict;
    $display("Checks made: %0d, mismatches: %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    #100us;
    err_total++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hb4f8));
    repeat (8) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rchk(CRF_OFF_STATUS, 0);
    for (int n = 0; n < CRF_NUM_REGS; n++) begin
      ref_q[n] = 8'($urandom);
      apb(1'b1, ra(n), {24'h0, ref_q[n]});
    end
    for (int n = 0; n < CRF_NUM_REGS; n++)
      rchk(ra(n), {24'h0, ref_q[n]});
    for (int p = 0; p < 3; p++)
      rchk(CRF_OFF_PTR_X + 12'(4 * p),
           {ref_q[27 + 2*p], ref_q[26 + 2*p]});
    apb(1'b1, CRF_OFF_PTR_Z, '1);
    chk(err_q, 1);
    rchk(12'h010, 0);
    chk(err_q, 1);
    for (int k = 0; k < 12; k++) begin
      {a_q, b_q} = k < 4 ? corner[k] : 16'($urandom);
      apb(1'b1, CRF_OFF_STATUS, 0);
      apb(1'b1, ra(2), a_q);
      apb(1'b1, ra(3), b_q);
      do_op(mk(CRF_OP_ADD, 2, 3));
      rchk(ra(2), 8'(a_q + b_q));
      rchk(CRF_OFF_STATUS,
        add_f(a_q, b_q));
    end
    apb(1'b1, ra(4), 8'h10);
    do_op(mk(CRF_OP_BST, 4, 0, CRF_PTR_X, CRF_AM_PLAIN, 4));
    do_op(mk(CRF_OP_BLD, 5, 0, CRF_PTR_X, CRF_AM_PLAIN, 7));
    rchk(CRF_OFF_STATUS, {add_f(a_q, b_q)} | 8'h40);
    rchk(ra(5), ref_q[5] | 8'h80);
    apb(1'b1, ra(26), 6);
    apb(1'b1, ra(27), 0);
    do_op(mk(CRF_OP_LD, 1, 0, CRF_PTR_X, CRF_AM_POSTINC));
    rchk(ra(1), ref_q[6]);
    rchk(CRF_OFF_PTR_X, 7);
    apb(1'b1, ra(28), 1);
    apb(1'b1, ra(29), 1);
    do_op(mk(CRF_OP_LD, 7, 0, CRF_PTR_Y, CRF_AM_PREDEC));
    rchk(ra(7), 8'h5A);
    rchk(CRF_OFF_PTR_Y, 16'h0100);
    do_op(mk(CRF_OP_ST, 2, 0, CRF_PTR_X, CRF_AM_POSTINC));
    rchk(ra(7), 8'(a_q + b_q));
    rchk(CRF_OFF_PTR_X, 8);
    do_op(mk(CRF_OP_LPM, 9, 0));
    rchk(ra(9), ref_q[30] ^ 8'h5A);
    do_op(mk(CRF_OP_IN, 10, 0));
    rchk(ra(10), 8'h7A);
    do_op(mk(CRF_OP_MOVW, 12, 26));
    rchk(ra(12), 8);
    apb(1'b1, CRF_OFF_STATUS, 8'hAD);
    @(posedge clk_sys_in);
    irq_req_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    irq_req_in <= 1'b0;
    rchk(CRF_OFF_STATUS, 8'h2D);
    chk(takes, 1);
    do_op(mk(CRF_OP_RETURN_FROM_IRQ_INSTR, 0, 0));
    rchk(CRF_OFF_STATUS, 8'hAD);
    do_op(mk(CRF_OP_CLI, 0, 0));
    rchk(CRF_OFF_STATUS, 8'h2D);
    do_op(mk(CRF_OP_SEI, 0, 0));
    rchk(CRF_OFF_STATUS, 8'hAD);
    give_verdict();
  end
endmodule : test_cpu_regfile_status_flags
`default_nettype wire
